//--- logic/timer8_pkg.sv
package timer8_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_CMP_A = 8'h0c;
  localparam logic [7:0] OFF_CMP_B = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;

  // Field positions in the control registers
  localparam int ACT_A_HI = 7;
  localparam int ACT_A_LO = 6;
  localparam int ACT_B_HI = 5;
  localparam int ACT_B_LO = 4;
  localparam int LOW_BITS_HI = 1;
  localparam int LOW_BITS_LO = 0;
  localparam int TOP_BIT_POS = 3;

  // Flag positions in the flag register
  localparam int FLAG_OVF = 0;
  localparam int FLAG_MATCH_A = 1;
  localparam int FLAG_MATCH_B = 2;

  // Reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic CTRL_B_TOP_RST = 1'b0;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [2:0] FLAGS_RST = 3'h0;

  // Count limits
  localparam logic [7:0] MAX_COUNT = 8'hff;
  localparam logic [7:0] BOTTOM_COUNT = 8'h00;

  // Wave mode encodings of interest
  localparam logic [2:0] MODE_FAST_TOP_CMP = 3'h7;

  typedef enum logic [1:0] {
    class_normal,
    class_clear_on_match,
    class_phase,
    class_fast
  } wave_class_t;

  // Per-channel events and settings handed to the waveform unit
  typedef struct packed {
    logic [1:0] action;
    logic allow_toggle;
    logic match;
    logic top_evt;
    logic up;
    logic cmp_eq_top;
  } chan_ctl_t;

endpackage : timer8_pkg

//--- logic/wave_output_unit.sv
`timescale 1ns/1ps
module wave_output_unit (
  input wire logic i_clock,
  input wire logic i_rstn,
  input timer8_pkg::wave_class_t i_class,
  input timer8_pkg::chan_ctl_t i_ctl,
  output logic o_level,
  output logic o_connected
);

  logic level_r;
  logic is_pwm;
  logic match_used;

  assign is_pwm = (i_class == timer8_pkg::class_phase) || (i_class == timer8_pkg::class_fast);
  // Match at top is dropped in PWM when the upper action bit is set
  assign match_used = i_ctl.match && !(is_pwm && i_ctl.action[1] && i_ctl.cmp_eq_top);

  // Toggle in PWM only where allowed; reserved codes stay off the pin
  assign o_connected = (i_ctl.action != 2'h0) &&
                       !(is_pwm && (i_ctl.action == 2'h1) && !i_ctl.allow_toggle);
  assign o_level = level_r;

  // Output level update per mode class
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      level_r <= 1'b0;
    end
    else
    begin
      case (i_class)
        timer8_pkg::class_fast:
        begin
          if (i_ctl.action[1] && i_ctl.top_evt)
          begin
            level_r <= !i_ctl.action[0];
          end
          else if (i_ctl.action[1] && match_used)
          begin
            level_r <= i_ctl.action[0];
          end
          else if ((i_ctl.action == 2'h1) && i_ctl.allow_toggle && match_used)
          begin
            level_r <= !level_r;
          end
        end
        timer8_pkg::class_phase:
        begin
          // Compare at top keeps the down-match level, so the duty sticks at full or zero
          if (i_ctl.action[1] && i_ctl.top_evt && i_ctl.cmp_eq_top)
          begin
            level_r <= !i_ctl.action[0];
          end
          else if (i_ctl.action[1] && match_used)
          begin
            level_r <= i_ctl.up ? i_ctl.action[0] : !i_ctl.action[0];
          end
          else if ((i_ctl.action == 2'h1) && i_ctl.allow_toggle && match_used)
          begin
            level_r <= !level_r;
          end
        end
        default:
        begin
          if (i_ctl.match)
          begin
            case (i_ctl.action)
              2'h1: level_r <= !level_r;
              2'h2: level_r <= 1'b0;
              2'h3: level_r <= 1'b1;
              default: level_r <= level_r;
            endcase
          end
        end
      endcase
    end
  end

endmodule : wave_output_unit

//--- logic/timer8_wave_compare_control.sv
`timescale 1ns/1ps
module timer8_wave_compare_control (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_timer_tick,
  input wire logic [2:0] i_vector_taken,
  input wire logic [1:0] i_pin_dir,
  output logic [1:0] o_compare_out,
  output logic [1:0] o_compare_oe_n,
  output logic [2:0] o_flags
);

  logic [7:0] ctrl_a_r;
  logic top_bit_r;
  logic [7:0] count_r;
  logic up_r;
  logic block_r;
  logic [7:0] cmp_buf_a_r;
  logic [7:0] cmp_buf_b_r;
  logic [7:0] cmp_act_a_r;
  logic [7:0] cmp_act_b_r;
  logic [2:0] flags_r;
  logic [31:0] prdata_r;
  logic [2:0] wave_mode;
  timer8_pkg::wave_class_t wclass;
  logic is_pwm;
  logic [7:0] top_val;
  logic top_evt;
  logic ovf_evt;
  logic [1:0] match;
  logic [1:0] level;
  logic [1:0] connected;
  logic setup_rd;
  logic access;
  logic hit;
  logic wr;
  logic [31:0] rd_mux;
  logic [2:0] flag_clr;
  logic [2:0] flag_set;
  timer8_pkg::chan_ctl_t ctl [2];

  // Wave mode decode; modes 4 and 6 fall back to plain counting
  assign wave_mode = {top_bit_r, ctrl_a_r[timer8_pkg::LOW_BITS_HI:timer8_pkg::LOW_BITS_LO]};
  always_comb
  begin
    case (wave_mode)
      3'h1, 3'h5: wclass = timer8_pkg::class_phase;
      3'h2: wclass = timer8_pkg::class_clear_on_match;
      3'h3, 3'h7: wclass = timer8_pkg::class_fast;
      default: wclass = timer8_pkg::class_normal;
    endcase
  end
  assign is_pwm = (wclass == timer8_pkg::class_phase) || (wclass == timer8_pkg::class_fast);

  // Top value source
  assign top_val = (wave_mode == 3'h2 || wave_mode == 3'h5 || wave_mode == 3'h7) ?
                   cmp_act_a_r : timer8_pkg::MAX_COUNT;

  // Top event: last tick before clearing in fast PWM, or the turn in dual slope
  assign top_evt = i_timer_tick && (count_r == top_val) &&
                   ((wclass == timer8_pkg::class_fast) ||
                    ((wclass == timer8_pkg::class_phase) && up_r));

  // Overflow event per mode
  always_comb
  begin
    case (wclass)
      timer8_pkg::class_phase:
        ovf_evt = i_timer_tick && !up_r && (count_r == timer8_pkg::BOTTOM_COUNT);
      default:
        ovf_evt = (wave_mode == timer8_pkg::MODE_FAST_TOP_CMP) ? top_evt :
                  (i_timer_tick && (count_r == timer8_pkg::MAX_COUNT));
    endcase
  end

  // Compare matches are blocked for one tick after a counter write
  assign match[0] = i_timer_tick && !block_r && (count_r == cmp_act_a_r);
  assign match[1] = i_timer_tick && !block_r && (count_r == cmp_act_b_r);

  // APB decode; one-cycle access, read data latched in setup
  assign access = i_psel && i_penable;
  assign setup_rd = i_psel && !i_penable && !i_pwrite;
  assign hit = (i_paddr == timer8_pkg::OFF_CTRL_A) || (i_paddr == timer8_pkg::OFF_CTRL_B) ||
               (i_paddr == timer8_pkg::OFF_COUNT) || (i_paddr == timer8_pkg::OFF_CMP_A) ||
               (i_paddr == timer8_pkg::OFF_CMP_B) || (i_paddr == timer8_pkg::OFF_FLAGS);
  assign wr = access && i_pwrite && hit;
  assign o_pready = 1'b1;
  assign o_pslverr = access && !hit;
  assign o_prdata = prdata_r;

  // Read mux; reserved bits come back as zero
  always_comb
  begin
    rd_mux = 32'h0;
    case (i_paddr)
      timer8_pkg::OFF_CTRL_A: rd_mux = {24'h0, ctrl_a_r[7:4], 2'h0, ctrl_a_r[1:0]};
      timer8_pkg::OFF_CTRL_B: rd_mux = {28'h0, top_bit_r, 3'h0};
      timer8_pkg::OFF_COUNT: rd_mux = {24'h0, count_r};
      timer8_pkg::OFF_CMP_A: rd_mux = {24'h0, cmp_buf_a_r};
      timer8_pkg::OFF_CMP_B: rd_mux = {24'h0, cmp_buf_b_r};
      timer8_pkg::OFF_FLAGS: rd_mux = {29'h0, flags_r};
      default: rd_mux = 32'h0;
    endcase
  end

  // Read data register
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      prdata_r <= 32'h0;
    end
    else if (setup_rd)
    begin
      prdata_r <= rd_mux;
    end
  end

  // Control registers; reserved bits never stored
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      ctrl_a_r <= timer8_pkg::CTRL_A_RST;
      top_bit_r <= timer8_pkg::CTRL_B_TOP_RST;
    end
    else if (wr && (i_paddr == timer8_pkg::OFF_CTRL_A))
    begin
      ctrl_a_r <= {i_pwdata[7:4], 2'h0, i_pwdata[1:0]};
    end
    else if (wr && (i_paddr == timer8_pkg::OFF_CTRL_B))
    begin
      top_bit_r <= i_pwdata[timer8_pkg::TOP_BIT_POS];
    end
  end

  // Compare buffers hold what software wrote
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      cmp_buf_a_r <= timer8_pkg::CMP_RST;
      cmp_buf_b_r <= timer8_pkg::CMP_RST;
    end
    else
    begin
      if (wr && (i_paddr == timer8_pkg::OFF_CMP_A))
      begin
        cmp_buf_a_r <= i_pwdata[7:0];
      end
      if (wr && (i_paddr == timer8_pkg::OFF_CMP_B))
      begin
        cmp_buf_b_r <= i_pwdata[7:0];
      end
    end
  end

  // Active compare values: straight through outside PWM, at top in PWM
  // so a new duty cycle never cuts a period short
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      cmp_act_a_r <= timer8_pkg::CMP_RST;
      cmp_act_b_r <= timer8_pkg::CMP_RST;
    end
    else if (!is_pwm)
    begin
      cmp_act_a_r <= (wr && (i_paddr == timer8_pkg::OFF_CMP_A)) ? i_pwdata[7:0] : cmp_buf_a_r;
      cmp_act_b_r <= (wr && (i_paddr == timer8_pkg::OFF_CMP_B)) ? i_pwdata[7:0] : cmp_buf_b_r;
    end
    else if (top_evt)
    begin
      cmp_act_a_r <= cmp_buf_a_r;
      cmp_act_b_r <= cmp_buf_b_r;
    end
  end

  // Counter; advances only on ticks, software write wins
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      count_r <= timer8_pkg::COUNT_RST;
      up_r <= 1'b1;
    end
    else if (wr && (i_paddr == timer8_pkg::OFF_COUNT))
    begin
      count_r <= i_pwdata[7:0];
    end
    else if (i_timer_tick)
    begin
      case (wclass)
        timer8_pkg::class_phase:
        begin
          if (up_r && (count_r == top_val))
          begin
            up_r <= 1'b0;
            count_r <= (top_val == timer8_pkg::BOTTOM_COUNT) ? count_r : count_r - 8'h01;
          end
          else if (!up_r && (count_r == timer8_pkg::BOTTOM_COUNT))
          begin
            up_r <= 1'b1;
            count_r <= (top_val == timer8_pkg::BOTTOM_COUNT) ? count_r : count_r + 8'h01;
          end
          else
          begin
            count_r <= up_r ? count_r + 8'h01 : count_r - 8'h01;
          end
        end
        timer8_pkg::class_clear_on_match, timer8_pkg::class_fast:
        begin
          up_r <= 1'b1;
          count_r <= (count_r == top_val) ? timer8_pkg::BOTTOM_COUNT : count_r + 8'h01;
        end
        default:
        begin
          up_r <= 1'b1;
          count_r <= count_r + 8'h01;
        end
      endcase
    end
  end

  // Match block after a counter write, released by the next tick
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      block_r <= 1'b0;
    end
    else if (wr && (i_paddr == timer8_pkg::OFF_COUNT))
    begin
      block_r <= 1'b1;
    end
    else if (i_timer_tick)
    begin
      block_r <= 1'b0;
    end
  end

  // Flags: hardware set wins over a clear in the same cycle
  assign flag_set = {match[1], match[0], ovf_evt};
  assign flag_clr = i_vector_taken |
                    ((wr && (i_paddr == timer8_pkg::OFF_FLAGS)) ? i_pwdata[2:0] : 3'h0);
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      flags_r <= timer8_pkg::FLAGS_RST;
    end
    else
    begin
      flags_r <= flag_set | (flags_r & ~flag_clr);
    end
  end
  assign o_flags = flags_r;

  // Per-channel event bundles and waveform units
  generate
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_chan
      assign ctl[ch].action = (ch == 0) ?
        ctrl_a_r[timer8_pkg::ACT_A_HI:timer8_pkg::ACT_A_LO] :
        ctrl_a_r[timer8_pkg::ACT_B_HI:timer8_pkg::ACT_B_LO];
      assign ctl[ch].allow_toggle = (ch == 0) ? top_bit_r : 1'b0;
      assign ctl[ch].match = match[ch];
      assign ctl[ch].top_evt = top_evt;
      assign ctl[ch].up = up_r;
      assign ctl[ch].cmp_eq_top = ((ch == 0) ? cmp_act_a_r : cmp_act_b_r) == top_val;
      wave_output_unit u_wave (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_class(wclass),
        .i_ctl(ctl[ch]),
        .o_level(level[ch]),
        .o_connected(connected[ch])
      );
      // Pin driven only when the channel owns it and direction is output
      assign o_compare_oe_n[ch] = !(connected[ch] && i_pin_dir[ch]);
      assign o_compare_out[ch] = level[ch];
    end
  endgenerate

  chk_reserved_read: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (setup_rd && i_paddr == timer8_pkg::OFF_CTRL_A) |=> (o_prdata[3:2] == 2'h0))
    else $error("control A reserved bits read nonzero");

  chk_pin_release: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (ctrl_a_r[7:6] == 2'h0) |-> o_compare_oe_n[0])
    else $error("pin A driven while action is off");

  chk_flag_a_set: assert property (@(posedge i_clock) disable iff (!i_rstn)
    match[0] |=> flags_r[timer8_pkg::FLAG_MATCH_A])
    else $error("match A flag not set");

  chk_ovf_normal: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (wave_mode == 3'h0 && i_timer_tick && count_r == 8'hff && !wr)
    |=> (flags_r[timer8_pkg::FLAG_OVF] && count_r == 8'h00))
    else $error("overflow at max missing");

  chk_ctc_clear: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (wclass == timer8_pkg::class_clear_on_match && match[0] && !wr) |=> (count_r == 8'h00))
    else $error("counter not cleared on match A");

  chk_fast_top_set: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (wclass == timer8_pkg::class_fast && ctrl_a_r[7:6] == 2'h2 && top_evt && !wr)
    |=> o_compare_out[0])
    else $error("fast PWM A not set at top");

  chk_phase_up_clear: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (wclass == timer8_pkg::class_phase && ctrl_a_r[7:6] == 2'h2 && match[0] && up_r &&
     cmp_act_a_r != top_val && !wr) |=> !o_compare_out[0])
    else $error("phase PWM A not cleared on up match");

  chk_cmp_buffered: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (is_pwm && !top_evt && !wr) |=> $stable(cmp_act_a_r))
    else $error("compare A changed away from top in PWM");

  chk_tick_gating: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (!i_timer_tick && !wr) |=> $stable(count_r))
    else $error("counter moved without a tick");

  chk_toggle_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (wclass == timer8_pkg::class_normal && ctrl_a_r[7:6] == 2'h1 && match[0] && !wr)
    |=> (o_compare_out[0] != $past(o_compare_out[0])))
    else $error("output A did not toggle");

  chk_b_reserved: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (is_pwm && ctrl_a_r[5:4] == 2'h1) |-> o_compare_oe_n[1])
    else $error("reserved B code drives pin");

endmodule : timer8_wave_compare_control

//--- bench/timer8_wave_compare_control_bench.sv
`timescale 1ns/1ps
module timer8_wave_compare_control_bench;
  logic i_clock;
  logic i_rstn;
  logic i_psel;
  logic i_penable;
  logic i_pwrite;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata;
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic i_timer_tick;
  logic [2:0] i_vector_taken;
  logic [1:0] i_pin_dir;
  logic [1:0] o_compare_out;
  logic [1:0] o_compare_oe_n;
  logic [2:0] o_flags;
  int bad_count;
  int compares;
  int cycles;
  logic [31:0] rd;
  logic slv;

  timer8_wave_compare_control uut (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .i_timer_tick(i_timer_tick),
    .i_vector_taken(i_vector_taken),
    .i_pin_dir(i_pin_dir),
    .o_compare_out(o_compare_out),
    .o_compare_oe_n(o_compare_oe_n),
    .o_flags(o_flags)
  );

  // 100 ns period clock
  always #50 i_clock = ~i_clock;

  task results;
    if (bad_count == 0 && compares > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // Guard against a hung handshake; the tests need well under a thousand cycles
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles > 5000)
    begin
      bad_count++;
      $display("[FAIL] %0t run did not finish in time", $time);
      results();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One APB transfer; request held until pready is seen at a rising edge
  task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= addr;
    i_pwdata <= data;
    @(posedge i_clock);
    i_penable <= 1'b1;
    // No wait limit here; only the cycle timeout ends a stuck transfer
    do
    begin
      @(posedge i_clock);
    end
    while (o_pready !== 1'b1);
    rd = o_prdata;
    slv = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] addr, input logic [7:0] data);
    apb(1'b1, addr, {24'h000000, data});
  endtask : wr

  task rdchk(input logic [7:0] addr, input logic [7:0] exp);
    apb(1'b0, addr, 32'h00000000);
    check(rd, {24'h000000, exp});
  endtask : rdchk

  // Each tick is a one-cycle enable pulse; outputs are looked at after the edge lands
  task tick(input int n);
    repeat (n)
    begin
      @(posedge i_clock);
      i_timer_tick <= 1'b1;
      @(posedge i_clock);
      i_timer_tick <= 1'b0;
    end
    #1;
  endtask : tick

  task do_reset;
    @(posedge i_clock);
    i_rstn <= 1'b0;
    i_pin_dir <= 2'b00;
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
  endtask : do_reset

  // Main sequence: registers, then each counting mode in turn
  initial
  begin
    logic [1:0] act;
    i_clock = 1'b0;
    i_rstn = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h00000000;
    i_timer_tick = 1'b0;
    i_vector_taken = 3'h0;
    i_pin_dir = 2'b00;
    bad_count = 0;
    compares = 0;
    cycles = 0;
    do_reset();
    rdchk(timer8_pkg::OFF_CTRL_A, 8'h00);
    rdchk(timer8_pkg::OFF_CTRL_B, 8'h00);
    rdchk(timer8_pkg::OFF_CMP_A, 8'h00);
    rdchk(timer8_pkg::OFF_FLAGS, 8'h00);
    check({30'h0, o_compare_oe_n}, 32'h3);
    check({30'h0, o_compare_out}, 32'h0);
    wr(timer8_pkg::OFF_CTRL_A, 8'hff);
    rdchk(timer8_pkg::OFF_CTRL_A, 8'hf3);
    wr(timer8_pkg::OFF_CTRL_B, 8'hff);
    rdchk(timer8_pkg::OFF_CTRL_B, 8'h08);
    apb(1'b0, 8'h3c, 32'h00000000);
    check({slv, rd[30:0]}, 32'h80000000);
    // Mode table: toggle action only overrides the pin where allowed
    i_pin_dir <= 2'b11;
    for (int m = 0; m < 8; m++)
    begin
      wr(timer8_pkg::OFF_CTRL_B, {4'h0, m[2], 3'h0});
      wr(timer8_pkg::OFF_CTRL_A, {8'h50 | {6'h00, m[1:0]}});
      #1;
      check({30'h0, o_compare_oe_n}, {30'h0, m[0], m[0] & ~m[2]});
    end
    // Normal mode: overflow at max, flag cleared by writing one
    do_reset();
    wr(timer8_pkg::OFF_COUNT, 8'hfe);
    tick(1);
    rdchk(timer8_pkg::OFF_COUNT, 8'hff);
    check({29'h0, o_flags}, 32'h0);
    tick(1);
    check({29'h0, o_flags}, 32'h1);
    rdchk(timer8_pkg::OFF_COUNT, 8'h00);
    wr(timer8_pkg::OFF_FLAGS, 8'h01);
    #1;
    check({29'h0, o_flags}, 32'h0);
    // Non-PWM actions on both channels; first tick after a count write has no match
    for (int a = 1; a < 4; a++)
    begin
      act = a[1:0];
      do_reset();
      wr(timer8_pkg::OFF_CMP_A, 8'h05);
      wr(timer8_pkg::OFF_CMP_B, 8'h05);
      wr(timer8_pkg::OFF_CTRL_A, {act, act, 4'h0});
      i_pin_dir <= 2'b11;
      wr(timer8_pkg::OFF_COUNT, 8'h03);
      tick(3);
      check({30'h0, o_compare_out}, (act == 2'b10) ? 32'h0 : 32'h3);
      check({30'h0, o_compare_oe_n}, 32'h0);
      check({29'h0, o_flags}, 32'h6);
      @(posedge i_clock);
      i_pin_dir <= 2'b00;
      #1;
      check({30'h0, o_compare_oe_n}, 32'h3);
    end
    // Clear-on-match mode with compare A as top
    do_reset();
    wr(timer8_pkg::OFF_CMP_A, 8'h03);
    wr(timer8_pkg::OFF_CTRL_A, 8'h02);
    wr(timer8_pkg::OFF_COUNT, 8'h00);
    tick(3);
    rdchk(timer8_pkg::OFF_COUNT, 8'h03);
    tick(1);
    rdchk(timer8_pkg::OFF_COUNT, 8'h00);
    check({29'h0, o_flags}, 32'h2);
    // Fast PWM: set at top, clear on match, compare update held until top
    do_reset();
    wr(timer8_pkg::OFF_CMP_A, 8'h02);
    wr(timer8_pkg::OFF_CTRL_A, 8'h93);
    i_pin_dir <= 2'b11;
    wr(timer8_pkg::OFF_COUNT, 8'hfe);
    check({30'h0, o_compare_oe_n}, 32'h2);
    tick(2);
    check({31'h0, o_compare_out[0]}, 32'h1);
    check({31'h0, o_flags[0]}, 32'h1);
    wr(timer8_pkg::OFF_CMP_A, 8'h05);
    rdchk(timer8_pkg::OFF_CMP_A, 8'h05);
    tick(3);
    check({31'h0, o_compare_out[0]}, 32'h0);
    // Phase-correct with compare A as top; A sits at top, B set up / clear down
    do_reset();
    wr(timer8_pkg::OFF_CMP_A, 8'h04);
    wr(timer8_pkg::OFF_CMP_B, 8'h02);
    wr(timer8_pkg::OFF_CTRL_B, 8'h08);
    wr(timer8_pkg::OFF_CTRL_A, 8'hb1);
    i_pin_dir <= 2'b11;
    tick(3);
    check({31'h0, o_compare_out[1]}, 32'h1);
    check({31'h0, o_compare_out[0]}, 32'h0);
    tick(4);
    check({31'h0, o_compare_out[1]}, 32'h0);
    check({31'h0, o_compare_out[0]}, 32'h1);
    tick(1);
    check({31'h0, o_flags[0]}, 32'h0);
    tick(1);
    check({31'h0, o_flags[0]}, 32'h1);
    // Taking the vector clears only its own flag
    @(posedge i_clock);
    i_vector_taken <= 3'b001;
    @(posedge i_clock);
    i_vector_taken <= 3'b000;
    #1;
    check({31'h0, o_flags[0]}, 32'h0);
    // Fast PWM with compare A as top: toggle allowed, overflow at top
    do_reset();
    wr(timer8_pkg::OFF_CMP_A, 8'h03);
    wr(timer8_pkg::OFF_CTRL_B, 8'h08);
    wr(timer8_pkg::OFF_CTRL_A, 8'h43);
    i_pin_dir <= 2'b11;
    tick(4);
    check({29'h0, o_flags}, 32'h7);
    check({31'h0, o_compare_out[0]}, 32'h1);
    check({30'h0, o_compare_oe_n}, 32'h2);
    rdchk(timer8_pkg::OFF_COUNT, 8'h00);
    tick(4);
    check({31'h0, o_compare_out[0]}, 32'h0);
    results();
  end
endmodule : timer8_wave_compare_control_bench
